// ---- cmp_ctrl.sv ----
// Dual comparator control: mode decode, polarity, change flag, pin routing, APB registers.
// Assumes raw comparator results are asynchronous; pins resolved outside from enables.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module cmp_ctrl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] cmp_raw,
    input wire logic [6:0] port_f_in,
    input wire logic [6:0] port_f_latch,
    output logic [6:0] port_f_out,
    output logic [6:0] port_f_oe,
    output logic cmp_a_on,
    output logic cmp_b_on,
    output logic ref_to_plus,
    output logic neg_sel_b,
    output logic [3:0] analog_pin_config,
    output logic irq,
    output logic wake
);
    cmp_ctrl_pkg::state_t s_r;
    cmp_ctrl_pkg::state_t s_nxt;
    cmp_ctrl_pkg::route_t rt;
    logic [1:0] res;
    logic acc;
    logic wr;
    logic rd;
    logic [6:0] analog_mask;

    function automatic cmp_ctrl_pkg::route_t decode(input logic [2:0] m, input logic sw);
        cmp_ctrl_pkg::route_t r;
        r = '0;
        unique case (m)
            3'h0: r = '0;
            3'h1: r = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
            3'h2: r = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            3'h3: r = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
            3'h4: r = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
            3'h5: r = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            3'h6: r = '{1'b1, 1'b1, 1'b1, sw, 1'b0};
            3'h7: r = '0;
        endcase
        return r;
    endfunction : decode

    // Analog pin mask from config field: fewer pins analog as code rises
    function automatic logic [6:0] amask(input logic [3:0] c);
        logic [6:0] m;
        m = 7'h00;
        if (c < 4'h4) begin
            m = 7'h3f;
        end else if (c < 4'h8) begin
            m = 7'h3c;
        end
        return m;
    endfunction : amask

    assign rt = decode(s_r.mode, s_r.sw);
    assign res = s_r.sync2 ^ s_r.inv;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign analog_mask = amask(s_r.acfg);

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = cmp_raw;
        s_nxt.sync2 = s_r.sync1;
        if (res != s_r.latched) begin
            s_nxt.flag = 1'b1;
        end
        if (acc && paddr == cmp_ctrl_pkg::ctrl_off) begin
            s_nxt.latched = res;
        end
        if (wr) begin
            unique case (paddr)
                cmp_ctrl_pkg::ctrl_off: begin
                    s_nxt.inv = pwdata[cmp_ctrl_pkg::inv_b_pos:cmp_ctrl_pkg::inv_a_pos];
                    s_nxt.sw = pwdata[cmp_ctrl_pkg::sw_pos];
                    s_nxt.mode = pwdata[2:0];
                end
                cmp_ctrl_pkg::flag_off: begin
                    if (!(res != s_r.latched)) begin
                        s_nxt.flag = pwdata[0];
                    end else begin
                        s_nxt.flag = 1'b1;
                    end
                end
                cmp_ctrl_pkg::ien_off: begin
                    s_nxt.cmp_en = pwdata[0];
                    s_nxt.periph_en = pwdata[1];
                    s_nxt.glob_en = pwdata[2];
                end
                cmp_ctrl_pkg::dir_off: s_nxt.dir = pwdata[6:0];
                cmp_ctrl_pkg::acfg_off: s_nxt.acfg = pwdata[3:0];
                default: s_nxt.dir = s_r.dir;
            endcase
        end
        s_nxt.prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                cmp_ctrl_pkg::ctrl_off: s_nxt.prdata = {24'h000000, res, s_r.inv, s_r.sw, s_r.mode};
                cmp_ctrl_pkg::flag_off: s_nxt.prdata = {31'h0, s_r.flag};
                cmp_ctrl_pkg::ien_off:
                    s_nxt.prdata = {29'h0, s_r.glob_en, s_r.periph_en, s_r.cmp_en};
                cmp_ctrl_pkg::port_off: s_nxt.prdata = {25'h0, port_f_in & ~analog_mask};
                cmp_ctrl_pkg::dir_off: s_nxt.prdata = {25'h0, s_r.dir};
                cmp_ctrl_pkg::acfg_off: s_nxt.prdata = {28'h0, s_r.acfg};
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.mode <= cmp_ctrl_pkg::ctrl_rst[2:0];
            s_r.dir <= cmp_ctrl_pkg::dir_rst;
            s_r.acfg <= cmp_ctrl_pkg::acfg_rst;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = acc && !(paddr == cmp_ctrl_pkg::ctrl_off || paddr == cmp_ctrl_pkg::flag_off
        || paddr == cmp_ctrl_pkg::ien_off || paddr == cmp_ctrl_pkg::port_off
        || paddr == cmp_ctrl_pkg::dir_off || paddr == cmp_ctrl_pkg::acfg_off);

    always_comb begin
        port_f_out = port_f_latch;
        if (rt.pin_out) begin
            port_f_out[0] = cmp_raw[0] ^ s_r.inv[0];
            port_f_out[1] = cmp_raw[1] ^ s_r.inv[1];
        end
    end
    assign port_f_oe = ~s_r.dir;
    assign cmp_a_on = rt.a_on;
    assign cmp_b_on = rt.b_on;
    assign ref_to_plus = rt.ref_plus;
    assign neg_sel_b = rt.neg_sel_b;
    assign analog_pin_config = s_r.acfg;
    assign irq = s_r.flag && s_r.cmp_en && s_r.periph_en && s_r.glob_en;
    assign wake = s_r.flag && s_r.cmp_en;

    property p_flag_on_change;
        @(posedge clk) disable iff (!nrst) (res != s_r.latched) |=> s_r.flag;
    endproperty
    a_flag_on_change: assert property (p_flag_on_change) else $error("flag missed");

    property p_irq_gate;
        @(posedge clk) disable iff (!nrst) irq |-> (s_r.flag && s_r.glob_en);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");

    property p_latch_on_access;
        @(posedge clk) disable iff (!nrst) (acc && paddr == cmp_ctrl_pkg::ctrl_off)
            |=> s_r.latched == $past(res);
    endproperty
    a_latch_on_access: assert property (p_latch_on_access) else $error("no latch");

    property p_mode_on_write;
        @(posedge clk) disable iff (!nrst) (wr && paddr == cmp_ctrl_pkg::ctrl_off)
            |=> s_r.mode == $past(pwdata[2:0]);
    endproperty
    a_mode_on_write: assert property (p_mode_on_write) else $error("mode lost");

    property p_off_mode;
        @(posedge clk) disable iff (!nrst) s_r.mode == cmp_ctrl_pkg::mode_off |-> !cmp_a_on && !cmp_b_on;
    endproperty
    a_off_mode: assert property (p_off_mode) else $error("off mode on");

    property p_ref_only_mux4;
        @(posedge clk) disable iff (!nrst) ref_to_plus |-> s_r.mode == cmp_ctrl_pkg::mode_mux4;
    endproperty
    a_ref_only_mux4: assert property (p_ref_only_mux4) else $error("ref routed");

    property p_switch;
        @(posedge clk) disable iff (!nrst) s_r.mode == cmp_ctrl_pkg::mode_mux4 |-> neg_sel_b == s_r.sw;
    endproperty
    a_switch: assert property (p_switch) else $error("switch wrong");

    property p_oe_dir;
        @(posedge clk) disable iff (!nrst) port_f_oe[1:0] == ~s_r.dir[1:0];
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("oe wrong");

    c_irq: cover property (@(posedge clk) disable iff (!nrst) irq);
    c_mux4: cover property (@(posedge clk) disable iff (!nrst) ref_to_plus && neg_sel_b);
    c_clear: cover property (@(posedge clk) disable iff (!nrst) s_r.flag ##1 !s_r.flag);
endmodule : cmp_ctrl

// ---- cmp_ctrl_pkg.sv ----
// Constants, register layout and carrier types for the dual comparator control block.
// Assumes an APB master on the system clock; analog results arrive asynchronously.
package cmp_ctrl_pkg;
    localparam logic [11:0] ctrl_off = 12'h000;
    localparam logic [11:0] flag_off = 12'h004;
    localparam logic [11:0] ien_off = 12'h008;
    localparam logic [11:0] port_off = 12'h00c;
    localparam logic [11:0] dir_off = 12'h010;
    localparam logic [11:0] acfg_off = 12'h014;
    localparam logic [7:0] ctrl_rst = 8'h07;
    localparam logic [6:0] dir_rst = 7'h7f;
    localparam logic [3:0] acfg_rst = 4'h0;
    localparam int unsigned res_b_pos = 7;
    localparam int unsigned res_a_pos = 6;
    localparam int unsigned inv_b_pos = 5;
    localparam int unsigned inv_a_pos = 4;
    localparam int unsigned sw_pos = 3;
    localparam logic [2:0] mode_mux4 = 3'h6;
    localparam logic [2:0] mode_off = 3'h7;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] latched;
        logic [1:0] inv;
        logic sw;
        logic [2:0] mode;
        logic flag;
        logic cmp_en;
        logic periph_en;
        logic glob_en;
        logic [6:0] dir;
        logic [3:0] acfg;
        logic [31:0] prdata;
    } state_t;

    // Per-mode analog routing
    typedef struct packed {
        logic a_on;
        logic b_on;
        logic ref_plus;
        logic neg_sel_b;
        logic pin_out;
    } route_t;
endpackage : cmp_ctrl_pkg

// ---- cmp_ctrl_tb_top.sv ----
// Bench for the comparator control block over APB.
// Assumes the far side model and the package offsets.
`timescale 1ns/1ps
module cmp_ctrl_tb_top;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, cmp_a_on, cmp_b_on;
    logic ref_to_plus, neg_sel_b, irq, wake;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] cmp_raw;
    logic e;
    logic [6:0] port_f_in, port_f_latch, port_f_out, port_f_oe, pin_ext;
    logic [3:0] analog_pin_config;
    logic [7:0] vref;
    logic [1:0][7:0] vp, vma, vmb;
    int n_errors = 0;
    int checks_done = 0;
    cmp_ctrl i_cmp_ctrl (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_raw(cmp_raw), .port_f_in(port_f_in),
        .port_f_latch(port_f_latch), .port_f_out(port_f_out), .port_f_oe(port_f_oe),
        .cmp_a_on(cmp_a_on), .cmp_b_on(cmp_b_on), .ref_to_plus(ref_to_plus),
        .neg_sel_b(neg_sel_b), .analog_pin_config(analog_pin_config), .irq(irq), .wake(wake));
    cmp_far_side i_cmp_far_side (.cmp_a_on(cmp_a_on), .cmp_b_on(cmp_b_on),
        .ref_to_plus(ref_to_plus), .neg_sel_b(neg_sel_b), .vref(vref), .vp(vp), .vma(vma),
        .vmb(vmb), .port_f_out(port_f_out), .port_f_oe(port_f_oe), .pin_ext(pin_ext),
        .cmp_raw(cmp_raw), .port_f_in(port_f_in));
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, exp);
    endtask : rd
    initial begin
        #25000;
        n_errors++;
        end_of_test();
    end
    initial begin
        nrst = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        port_f_latch = 7'h55; pin_ext = 7'h7f; vref = 8'h50;
        vp = {8'h40, 8'h40}; vma = {8'h20, 8'h20}; vmb = {8'h60, 8'h60};
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(cmp_ctrl_pkg::ctrl_off, 32'h07, "ctrl_rst");
        rd(cmp_ctrl_pkg::dir_off, 32'h7f, "dir_rst");
        rd(cmp_ctrl_pkg::acfg_off, 32'h0, "acfg_rst");
        chk("oe_rst", port_f_oe, 32'h0);
        apb(1'b1, cmp_ctrl_pkg::ctrl_off, 32'hce);
        chk("switch_b", {ref_to_plus, neg_sel_b, cmp_a_on, cmp_b_on}, 32'hf);
        repeat (4) @(posedge clk);
        rd(cmp_ctrl_pkg::ctrl_off, 32'h0e, "ro_res");
        apb(1'b1, cmp_ctrl_pkg::ctrl_off, 32'h06);
        repeat (4) @(posedge clk);
        rd(cmp_ctrl_pkg::ctrl_off, 32'hc6, "res_hi");
        rd(cmp_ctrl_pkg::flag_off, 32'h1, "flag_set");
        chk("irq_off", irq, 32'h0);
        apb(1'b1, cmp_ctrl_pkg::ctrl_off, 32'h36);
        repeat (4) @(posedge clk);
        rd(cmp_ctrl_pkg::ctrl_off, 32'h36, "inv");
        apb(1'b1, cmp_ctrl_pkg::flag_off, 32'h0);
        rd(cmp_ctrl_pkg::flag_off, 32'h0, "flag_clr");
        apb(1'b1, cmp_ctrl_pkg::flag_off, 32'h1);
        rd(cmp_ctrl_pkg::flag_off, 32'h1, "flag_soft");
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, cmp_ctrl_pkg::ien_off, 32'(i));
            chk("irq", {wake, irq}, {30'h0, i[0], i == 7});
        end
        vref <= 8'h10;
        repeat (4) @(posedge clk);
        apb(1'b1, cmp_ctrl_pkg::flag_off, 32'h0);
        rd(cmp_ctrl_pkg::flag_off, 32'h1, "mismatch");
        rd(cmp_ctrl_pkg::ctrl_off, 32'hf6, "inv_lo");
        apb(1'b1, cmp_ctrl_pkg::flag_off, 32'h0);
        rd(cmp_ctrl_pkg::flag_off, 32'h0, "flag_end");
        apb(1'b1, cmp_ctrl_pkg::ien_off, 32'h0);
        apb(1'b1, cmp_ctrl_pkg::ctrl_off, 32'h07);
        chk("off", {cmp_a_on, cmp_b_on, ref_to_plus}, 32'h0);
        apb(1'b1, cmp_ctrl_pkg::dir_off, 32'h0);
        chk("oe", port_f_oe, 32'h7f);
        apb(1'b1, cmp_ctrl_pkg::ctrl_off, 32'h13);
        repeat (4) @(posedge clk);
        chk("pin_out", port_f_out, 32'h56);
        apb(1'b1, cmp_ctrl_pkg::dir_off, 32'h7f);
        apb(1'b1, cmp_ctrl_pkg::acfg_off, 32'hf);
        rd(cmp_ctrl_pkg::port_off, 32'h7f, "port_dig");
        apb(1'b1, cmp_ctrl_pkg::acfg_off, 32'h0);
        rd(cmp_ctrl_pkg::port_off, 32'h40, "port_ana");
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped_err", e, 32'h1);
        chk("unmapped_q", q, 32'h0);
        end_of_test();
    end
endmodule : cmp_ctrl_tb_top

// ---- cmp_far_side.sv ----
// Analog far side: comparator front ends and port pin resolution.
// Assumes levels are plain codes; a comparator that is off reads low.
`timescale 1ns/1ps
module cmp_far_side (
    input wire logic cmp_a_on,
    input wire logic cmp_b_on,
    input wire logic ref_to_plus,
    input wire logic neg_sel_b,
    input wire logic [7:0] vref,
    input wire logic [1:0][7:0] vp,
    input wire logic [1:0][7:0] vma,
    input wire logic [1:0][7:0] vmb,
    input wire logic [6:0] port_f_out,
    input wire logic [6:0] port_f_oe,
    input wire logic [6:0] pin_ext,
    output logic [1:0] cmp_raw,
    output logic [6:0] port_f_in
);
    logic [1:0] on;
    assign on = {cmp_b_on, cmp_a_on};
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cmp_raw[i] = on[i] && ((ref_to_plus ? vref : vp[i]) > (neg_sel_b ? vmb[i] : vma[i]));
        end
    end
    assign port_f_in = (port_f_oe & port_f_out) | (~port_f_oe & pin_ext);
endmodule : cmp_far_side
